// ==== rtl/slrtc_dev.sv ====
// receive-side lane pattern, sample and code-group test logic with its registers
// Notes on behaviour
// RULE1: pattern checker runs without link established
// RULE2: selector picks PRBS7, PRBS15 or PRBS31
// RULE3: one enable bit per physical lane
// RULE4: controller pulses checker clear before test
// RULE5: test starts on rising edge of go
// RULE6: controller runs test 500 ms, then stops
// RULE7: pass flags per lane, one means pass
// RULE8: lane selector routes 24-bit error tally
// RULE9: error tally saturates at all ones
// RULE10: many lanes checked, one tally shown
// RULE11: sample test only on synchronized link
// RULE12: converter and sample index selectors
// RULE13: 16-bit reference in high/low registers
// RULE14: sample test enable and clear bits
// RULE15: fail flag, zero pass, one fail
// RULE16: transmitter repeats unique samples per converter
// RULE17: K28.5 stream releases sync, sets status
// RULE18: link select picks link 0 or 1 status
// RULE19: receiver gets halved lanes, one converter
// RULE20: lane-count bit 7 enables descrambling
// RULE21: mode 11 lane masks equal 0x33
// RULE22: mode 12 lane masks equal 0x11
`timescale 1ns/1ps
`default_nettype none
module slrtc_dev (
	input  wire logic                clk,
	input  wire logic                ce,
	input  wire logic                nrst,
	input  wire logic [11:0]         reg_addr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_we,
	output logic      [7:0]          reg_rdata,
	output logic                     descramble_en,
	output logic      [4:0]          lanes_per_link_m1,
	slrtc_link_if.dev                link
);
	import slrtc_pkg::*;

	typedef struct packed {
		logic [7:0]                 link_cfg;
		logic [7:0]                 lane_en;
		logic [7:0]                 test_ctl;
		logic [23:0]                limit;
		logic [7:0]                 short_transport_check_ctl;
		logic [15:0]                ref_smp;
		logic [7:0]                 l_cfg;
		logic [7:0]                 f_cfg;
		logic [7:0]                 k_cfg;
		logic [7:0]                 m_cfg;
		logic [7:0]                 n_cfg;
		logic [7:0]                 np_cfg;
		logic [7:0]                 s_cfg;
		logic [7:0]                 hd_cfg;
		logic [7:0]                 deskew;
		logic [7:0]                 f_copy;
		logic [7:0]                 lane_mask;
		logic                       go_d;
		logic                       running;
		logic [LANES-1:0][HIST_W-1:0] hist;
		logic [LANES-1:0][4:0]      warm;
		logic [LANES-1:0][TALLY_W-1:0] tally;
		logic                       short_transport_check_fail;
		logic [LANES-1:0][2:0]      kcnt;
		logic [7:0]                 cgs_ok;
		logic                       sync_n;
		logic [7:0]                 rdata;
	} slrtc_dev_st_t;

	slrtc_dev_st_t st_r;
	slrtc_dev_st_t st_nxt;
	logic [1:0]         pat_sel;
	logic [2:0]         tally_sel;
	logic [7:0]         pass_flags;
	logic [7:0]         cgs_view;
	logic [TALLY_W-1:0] tally_shown;
	logic               expect_bit;
	logic [7:0]         wdat;

	assign pat_sel           = st_r.test_ctl[B_PAT_LO +: 2];
	assign tally_sel         = st_r.test_ctl[B_SEL_LO +: 3];
	assign tally_shown       = st_r.tally[tally_sel]; // RULE8 RULE10
	assign reg_rdata         = st_r.rdata;
	assign descramble_en     = st_r.l_cfg[B_DESCR]; // RULE20
	assign lanes_per_link_m1 = st_r.l_cfg[4:0]; // RULE19
	assign link.sync_request_out_n = st_r.sync_n;

	always_comb begin
		st_nxt     = st_r;
		expect_bit = 1'b0;
		wdat       = reg_wdata;
		pass_flags = 8'h00;
		for (int i = 0; i < LANES; i++) begin
			pass_flags[i] = st_r.lane_en[i] && (st_r.tally[i] <= st_r.limit); // RULE7
		end
		// link 1 lanes appear in the low half when selected
		cgs_view = st_r.link_cfg[B_LINK_SEL] ? {4'h0, st_r.cgs_ok[7:4]}
			: st_r.cgs_ok; // RULE18

		if (reg_we) begin
			case (reg_addr)
				A_LINK_CFG:  st_nxt.link_cfg       = wdat;
				A_LANE_EN:   st_nxt.lane_en        = wdat; // RULE3
				A_TEST_CTL:  st_nxt.test_ctl       = wdat; // RULE2
				A_LIM_L:     st_nxt.limit[7:0]     = wdat;
				A_LIM_M:     st_nxt.limit[15:8]    = wdat;
				A_LIM_H:     st_nxt.limit[23:16]   = wdat;
				A_SHORT_TRANSPORT_CHECK_CTL:  st_nxt.short_transport_check_ctl       = wdat; // RULE12 RULE14
				A_REF_L:     st_nxt.ref_smp[7:0]   = wdat; // RULE13
				A_REF_H:     st_nxt.ref_smp[15:8]  = wdat; // RULE13
				A_L_CFG:     st_nxt.l_cfg          = wdat;
				A_F_CFG:     st_nxt.f_cfg          = wdat;
				A_K_CFG:     st_nxt.k_cfg          = wdat;
				A_M_CFG:     st_nxt.m_cfg          = wdat; // RULE19
				A_N_CFG:     st_nxt.n_cfg          = wdat;
				A_NP_CFG:    st_nxt.np_cfg         = wdat;
				A_S_CFG:     st_nxt.s_cfg          = wdat;
				A_HD_CFG:    st_nxt.hd_cfg         = wdat;
				A_DESKEW:    st_nxt.deskew         = wdat; // RULE21 RULE22
				A_F_COPY:    st_nxt.f_copy         = wdat;
				A_LANE_MASK: st_nxt.lane_mask      = wdat; // RULE21 RULE22
				default:     st_nxt.link_cfg       = st_r.link_cfg;
			endcase
		end

		case (reg_addr)
			A_LINK_CFG:  st_nxt.rdata = st_r.link_cfg;
			A_LANE_EN:   st_nxt.rdata = st_r.lane_en;
			A_TEST_CTL:  st_nxt.rdata = st_r.test_ctl;
			A_LIM_L:     st_nxt.rdata = st_r.limit[7:0];
			A_LIM_M:     st_nxt.rdata = st_r.limit[15:8];
			A_LIM_H:     st_nxt.rdata = st_r.limit[23:16];
			A_CNT_L:     st_nxt.rdata = tally_shown[7:0];
			A_CNT_M:     st_nxt.rdata = tally_shown[15:8];
			A_CNT_H:     st_nxt.rdata = tally_shown[23:16];
			A_PASS:      st_nxt.rdata = pass_flags;
			A_SHORT_TRANSPORT_CHECK_CTL:  st_nxt.rdata = st_r.short_transport_check_ctl;
			A_REF_L:     st_nxt.rdata = st_r.ref_smp[7:0];
			A_REF_H:     st_nxt.rdata = st_r.ref_smp[15:8];
			A_SHORT_TRANSPORT_CHECK_RES:  st_nxt.rdata = {7'h00, st_r.short_transport_check_fail}; // RULE15
			A_L_CFG:     st_nxt.rdata = st_r.l_cfg;
			A_F_CFG:     st_nxt.rdata = st_r.f_cfg;
			A_K_CFG:     st_nxt.rdata = st_r.k_cfg;
			A_M_CFG:     st_nxt.rdata = st_r.m_cfg;
			A_N_CFG:     st_nxt.rdata = st_r.n_cfg;
			A_NP_CFG:    st_nxt.rdata = st_r.np_cfg;
			A_S_CFG:     st_nxt.rdata = st_r.s_cfg;
			A_HD_CFG:    st_nxt.rdata = st_r.hd_cfg;
			A_DESKEW:    st_nxt.rdata = st_r.deskew;
			A_CGS_STAT:  st_nxt.rdata = cgs_view; // RULE17
			A_F_COPY:    st_nxt.rdata = st_r.f_copy;
			A_LANE_MASK: st_nxt.rdata = st_r.lane_mask;
			default:     st_nxt.rdata = 8'h00;
		endcase

		// go edge detection; stopping is a plain write of zero
		st_nxt.go_d = st_r.test_ctl[B_GO];
		if (!st_r.test_ctl[B_GO]) begin
			st_nxt.running = 1'b0;
		end else if (!st_r.go_d) begin
			st_nxt.running = 1'b1; // RULE5
		end

		// lane checkers self-synchronise on raw bits, no link needed
		for (int i = 0; i < LANES; i++) begin
			case (pat_sel)
				PAT_PRBS15: expect_bit = st_r.hist[i][14] ^ st_r.hist[i][13];
				PAT_PRBS31: expect_bit = st_r.hist[i][30] ^ st_r.hist[i][27];
				default:    expect_bit = st_r.hist[i][6] ^ st_r.hist[i][5]; // RULE2
			endcase
			if (st_r.test_ctl[B_CLEAR]) begin
				st_nxt.tally[i] = '0;
				st_nxt.warm[i]  = 5'h00;
			end else if (st_r.running && st_r.lane_en[i]) begin // RULE1 RULE3 RULE10
				st_nxt.hist[i] = {st_r.hist[i][HIST_W-2:0], link.lane_bit[i]};
				if (st_r.warm[i] != WARM_BITS) begin
					st_nxt.warm[i] = st_r.warm[i] + 5'h01;
				end else if ((link.lane_bit[i] != expect_bit) && !(&st_r.tally[i])) begin
					st_nxt.tally[i] = st_r.tally[i] + 24'h000001; // RULE9
				end
			end
		end

		// sample comparator; a mismatch in the clear cycle still sets the flag
		if (st_r.short_transport_check_ctl[B_SHORT_TRANSPORT_CHECK_CLR]) begin
			st_nxt.short_transport_check_fail = 1'b0; // RULE14
		end
		if (st_r.short_transport_check_ctl[B_SHORT_TRANSPORT_CHECK_EN] && link.smp_valid
			&& (link.smp_conv == st_r.short_transport_check_ctl[B_CONV_LO +: 2])
			&& (link.smp_idx == st_r.short_transport_check_ctl[B_IDX_LO +: 2])
			&& (link.smp_data != st_r.ref_smp)) begin
			st_nxt.short_transport_check_fail = 1'b1; // RULE12 RULE15
		end

		// code-group sync: five K28.5 in a row on each enabled lane
		for (int i = 0; i < LANES; i++) begin
			if (!st_r.lane_mask[i] || !link.cgs_k[i]) begin
				st_nxt.kcnt[i]   = 3'h0;
				st_nxt.cgs_ok[i] = 1'b0;
			end else if (st_r.kcnt[i] != CGS_CHARS) begin
				st_nxt.kcnt[i] = st_r.kcnt[i] + 3'h1;
			end else begin
				st_nxt.cgs_ok[i] = 1'b1; // RULE17
			end
		end
		st_nxt.sync_n = (st_r.lane_mask != 8'h00)
			&& ((st_r.cgs_ok & st_r.lane_mask) == st_r.lane_mask); // RULE17
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end
endmodule : slrtc_dev
`default_nettype wire

// ==== rtl/slrtc_link_if.sv ====
// link between transmitter and receive-side checker
`timescale 1ns/1ps
`default_nettype none
interface slrtc_link_if;
	logic [7:0]  lane_bit;
	logic [7:0]  cgs_k;
	logic        smp_valid;
	logic [1:0]  smp_conv;
	logic [1:0]  smp_idx;
	logic [15:0] smp_data;
	logic        sync_request_out_n;
	modport dev (input lane_bit, cgs_k, smp_valid, smp_conv, smp_idx, smp_data,
		output sync_request_out_n);
	modport tx (output lane_bit, cgs_k, smp_valid, smp_conv, smp_idx, smp_data,
		input sync_request_out_n);
endinterface : slrtc_link_if
`default_nettype wire

// ==== rtl/slrtc_pkg.sv ====
// shared constants for the lane test checker and its transmitter
package slrtc_pkg;
	localparam int          LANES          = 8;
	localparam int          TALLY_W        = 24;
	localparam int          HIST_W         = 31;
	localparam logic [4:0]  WARM_BITS      = 5'h1f;
	localparam logic [2:0]  CGS_CHARS      = 3'h4;
	// register offsets
	localparam logic [11:0] A_LINK_CFG     = 12'h300;
	localparam logic [11:0] A_LANE_EN      = 12'h315;
	localparam logic [11:0] A_TEST_CTL     = 12'h316;
	localparam logic [11:0] A_LIM_L        = 12'h317;
	localparam logic [11:0] A_LIM_M        = 12'h318;
	localparam logic [11:0] A_LIM_H        = 12'h319;
	localparam logic [11:0] A_CNT_L        = 12'h31a;
	localparam logic [11:0] A_CNT_M        = 12'h31b;
	localparam logic [11:0] A_CNT_H        = 12'h31c;
	localparam logic [11:0] A_PASS         = 12'h31d;
	localparam logic [11:0] A_SHORT_TRANSPORT_CHECK_CTL     = 12'h32c;
	localparam logic [11:0] A_REF_L        = 12'h32d;
	localparam logic [11:0] A_REF_H        = 12'h32e;
	localparam logic [11:0] A_SHORT_TRANSPORT_CHECK_RES     = 12'h32f;
	localparam logic [11:0] A_L_CFG        = 12'h453;
	localparam logic [11:0] A_F_CFG        = 12'h454;
	localparam logic [11:0] A_K_CFG        = 12'h455;
	localparam logic [11:0] A_M_CFG        = 12'h456;
	localparam logic [11:0] A_N_CFG        = 12'h457;
	localparam logic [11:0] A_NP_CFG       = 12'h458;
	localparam logic [11:0] A_S_CFG        = 12'h459;
	localparam logic [11:0] A_HD_CFG       = 12'h45a;
	localparam logic [11:0] A_DESKEW       = 12'h46c;
	localparam logic [11:0] A_CGS_STAT     = 12'h470;
	localparam logic [11:0] A_F_COPY       = 12'h476;
	localparam logic [11:0] A_LANE_MASK    = 12'h47d;
	// field positions
	localparam int          B_CLEAR        = 0;
	localparam int          B_GO           = 1;
	localparam int          B_PAT_LO       = 2;
	localparam int          B_SEL_LO       = 4;
	localparam int          B_SHORT_TRANSPORT_CHECK_EN      = 0;
	localparam int          B_SHORT_TRANSPORT_CHECK_CLR     = 1;
	localparam int          B_CONV_LO      = 2;
	localparam int          B_IDX_LO       = 4;
	localparam int          B_DESCR        = 7;
	localparam int          B_LINK_SEL     = 2;
	localparam logic [7:0]  REG_RESET      = 8'h00;
	// pattern selector codes
	localparam logic [1:0]  PAT_PRBS7      = 2'h0;
	localparam logic [1:0]  PAT_PRBS15     = 2'h1;
	localparam logic [1:0]  PAT_PRBS31     = 2'h2;
	// transmit side true parameters per mode
	localparam logic [3:0]  MODE_11        = 4'hb;
	localparam logic [3:0]  MODE_12        = 4'hc;
	localparam logic [3:0]  TX_L_MODE11    = 4'h4;
	localparam logic [3:0]  TX_L_MODE12    = 4'h2;
	localparam logic [1:0]  TX_M_TRUE      = 2'h2;
	localparam logic [1:0]  TX_S_TRUE      = 2'h1;
	localparam logic [7:0]  MASK_MODE11    = 8'h33;
	localparam logic [7:0]  MASK_MODE12    = 8'h11;
	// timing
	localparam int          CLK_HZ         = 40000000;
	localparam int          RUN_MS         = 500;
	localparam int          RUN_CYCLES     = CLK_HZ / 1000 * RUN_MS;
	localparam int          RUN_W          = 25;
endpackage : slrtc_pkg

// ==== rtl/slrtc_tx.sv ====
// transmitter end: PRBS lanes, K28.5 stream and short transport samples
`timescale 1ns/1ps
`default_nettype none
module slrtc_tx #(
	parameter int                    RUN_LEN = slrtc_pkg::RUN_CYCLES
) (
	input  wire logic                clk,
	input  wire logic                ce,
	input  wire logic                nrst,
	input  wire logic [1:0]          pat_sel,
	input  wire logic [7:0]          prbs_lanes,
	input  wire logic                prbs_start,
	output logic                     prbs_run_done,
	input  wire logic                cgs_send,
	input  wire logic                short_transport_check_en,
	input  wire logic [15:0]         short_transport_check_base,
	input  wire logic [3:0]          mode,
	output logic      [3:0]          tx_lanes,
	output logic      [1:0]          tx_convs,
	output logic      [7:0]          rx_lane_mask,
	slrtc_link_if.tx                 link
);
	import slrtc_pkg::*;

	typedef enum logic [1:0] {IDLE, RUN, DONE} slrtc_run_t;

	typedef struct packed {
		slrtc_run_t       run;
		logic [RUN_W-1:0] cnt;
		logic [HIST_W-1:0] hist;
		logic [7:0]       lane_bit;
		logic [7:0]       cgs_k;
		logic             smp_valid;
		logic [1:0]       conv;
		logic [1:0]       idx;
		logic [15:0]      smp_data;
	} slrtc_tx_st_t;

	slrtc_tx_st_t st_r;
	slrtc_tx_st_t st_nxt;
	logic         fb;

	assign prbs_run_done  = (st_r.run == DONE);
	assign link.lane_bit  = st_r.lane_bit;
	assign link.cgs_k     = st_r.cgs_k;
	assign link.smp_valid = st_r.smp_valid;
	assign link.smp_conv  = st_r.conv;
	assign link.smp_idx   = st_r.idx;
	assign link.smp_data  = st_r.smp_data;
	assign tx_convs       = TX_M_TRUE; // RULE19
	assign tx_lanes       = (mode == MODE_12) ? TX_L_MODE12 : TX_L_MODE11; // RULE19
	assign rx_lane_mask   = (mode == MODE_12) ? MASK_MODE12 : MASK_MODE11; // RULE21 RULE22

	always_comb begin
		st_nxt = st_r;
		case (pat_sel)
			PAT_PRBS15: fb = st_r.hist[14] ^ st_r.hist[13];
			PAT_PRBS31: fb = st_r.hist[30] ^ st_r.hist[27];
			default:    fb = st_r.hist[6] ^ st_r.hist[5];
		endcase
		st_nxt.hist     = {st_r.hist[HIST_W-2:0], fb};
		st_nxt.lane_bit = (st_r.run == RUN) ? ({8{fb}} & prbs_lanes) : 8'h00;
		st_nxt.cgs_k    = cgs_send ? 8'hff : 8'h00;
		// pattern window length is the controller's timed run
		case (st_r.run)
			IDLE: begin
				if (prbs_start) begin
					st_nxt.run = RUN;
					st_nxt.cnt = '0;
				end
			end
			RUN: begin
				st_nxt.cnt = st_r.cnt + 25'h0000001;
				if (st_r.cnt == RUN_W'(RUN_LEN - 1)) begin
					st_nxt.run = DONE; // RULE6
				end
			end
			DONE: st_nxt.run = IDLE;
			default: st_nxt.run = IDLE;
		endcase
		// samples only once the receiver has released its sync request
		st_nxt.smp_valid = short_transport_check_en && link.sync_request_out_n; // RULE11
		if (st_nxt.smp_valid) begin
			if (st_r.idx == TX_S_TRUE - 2'h1) begin
				st_nxt.idx  = 2'h0;
				st_nxt.conv = (st_r.conv == TX_M_TRUE - 2'h1) ? 2'h0 : st_r.conv + 2'h1;
			end else begin
				st_nxt.idx = st_r.idx + 2'h1;
			end
			// labels leave with the sample they name
			st_nxt.smp_data = short_transport_check_base + {12'h000, st_nxt.conv, st_nxt.idx}; // RULE16
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_r      <= '0;
			st_r.run  <= IDLE;
			st_r.hist <= '1;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end
endmodule : slrtc_tx
`default_nettype wire

// ==== testbench/slrtc_link_properties.sv ====
// interface checks between transmitter and receive-side checker
`timescale 1ns/1ps
`default_nettype none
module slrtc_link_properties (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [7:0]  lane_bit,
	input  wire logic [7:0]  cgs_k,
	input  wire logic        smp_valid,
	input  wire logic [1:0]  smp_conv,
	input  wire logic [1:0]  smp_idx,
	input  wire logic [15:0] smp_data,
	input  wire logic        sync_request_out_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_reset_link_idle: assert property ($rose(nrst) |->
		lane_bit == 8'h00 && !smp_valid && !sync_request_out_n)
		else $error("link not idle after reset");
	a_sync_needs_chars: assert property ((!sync_request_out_n && cgs_k == 8'h00) [*3] |=>
		!sync_request_out_n)
		else $error("sync released without characters");
	a_sync_after_chars: assert property ($rose(sync_request_out_n) |->
		$past(cgs_k, 3) != 8'h00 && $past(cgs_k, 5) != 8'h00)
		else $error("sync released too early");
	a_sync_holds_on: assert property (sync_request_out_n && cgs_k == 8'hff |=>
		sync_request_out_n)
		else $error("sync dropped during character stream");
	a_sample_needs_sync: assert property (smp_valid |-> $past(sync_request_out_n))
		else $error("sample sent before sync release");
	a_sample_index_range: assert property (smp_valid |->
		smp_conv < 2'h2 && smp_idx == 2'h0)
		else $error("sample index out of range");
	a_conv_alternates: assert property (smp_valid && $past(smp_valid) |->
		smp_conv != $past(smp_conv))
		else $error("converter index did not advance");
	a_sample_value_step: assert property (smp_valid && $past(smp_valid) |->
		smp_data - $past(smp_data) == (smp_conv[0] ? 16'h0004 : 16'hfffc))
		else $error("sample values not unique per converter");
endmodule : slrtc_link_properties
`default_nettype wire

// ==== testbench/tb_serial_link_rx_test_checker.sv ====
// bench for the lane test checker and its transmitter
`timescale 1ns/1ps
`default_nettype none
module tb_serial_link_rx_test_checker;
	import slrtc_pkg::*;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_we = 1'b0;
	logic [7:0]  reg_rdata;
	logic        descramble_en;
	logic [4:0]  lanes_per_link_m1;
	logic [1:0]  pat_sel = 2'h0;
	logic [7:0]  prbs_lanes = 8'h0f;
	logic        prbs_start = 1'b0;
	logic        prbs_run_done;
	logic        cgs_send = 1'b0;
	logic        short_transport_check_en = 1'b0;
	logic [15:0] short_transport_check_base = 16'h1230;
	logic [3:0]  mode = MODE_11;
	logic [3:0]  tx_lanes;
	logic [1:0]  tx_convs;
	logic [7:0]  rx_lane_mask;
	int          bad_count = 0;
	int          cmp_count = 0;
	int          i;
	int          n;
	logic [23:0] t;
	logic [11:0] zero_a [8] = '{A_LANE_EN, A_TEST_CTL, A_PASS, A_SHORT_TRANSPORT_CHECK_RES, A_CGS_STAT,
		A_L_CFG, A_CNT_L, 12'h123};
	logic [11:0] rw_a [15] = '{A_LANE_EN, A_LIM_L, A_LIM_M, A_LIM_H, A_REF_L, A_REF_H,
		A_F_CFG, A_K_CFG, A_M_CFG, A_N_CFG, A_S_CFG, A_HD_CFG, A_DESKEW, A_F_COPY, A_NP_CFG};
	logic [1:0]  pats [3] = '{PAT_PRBS7, PAT_PRBS15, PAT_PRBS31};
	logic [1:0]  cvs [4] = '{2'h0, 2'h1, 2'h0, 2'h0};
	logic [1:0]  idxs [4] = '{2'h0, 2'h0, 2'h0, 2'h1};
	logic [15:0] flip [4] = '{16'h0000, 16'h0000, 16'h0100, 16'h0100};

	slrtc_link_if link ();
	always #12.5 clk = ~clk;

	slrtc_dev i_slrtc_dev (.clk(clk), .ce(1'b1), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata),
		.descramble_en(descramble_en), .lanes_per_link_m1(lanes_per_link_m1), .link(link.dev));
	slrtc_tx #(.RUN_LEN(400)) i_slrtc_tx (.clk(clk), .ce(1'b1), .nrst(nrst), .pat_sel(pat_sel),
		.prbs_lanes(prbs_lanes), .prbs_start(prbs_start), .prbs_run_done(prbs_run_done),
		.cgs_send(cgs_send), .short_transport_check_en(short_transport_check_en), .short_transport_check_base(short_transport_check_base), .mode(mode),
		.tx_lanes(tx_lanes), .tx_convs(tx_convs), .rx_lane_mask(rx_lane_mask), .link(link.tx));
	slrtc_link_properties i_slrtc_link_properties (.clk(clk), .nrst(nrst),
		.lane_bit(link.lane_bit), .cgs_k(link.cgs_k), .smp_valid(link.smp_valid),
		.smp_conv(link.smp_conv), .smp_idx(link.smp_idx), .smp_data(link.smp_data),
		.sync_request_out_n(link.sync_request_out_n));

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_we = 1'b1;
		@(posedge clk) #1;
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		reg_we = 1'b0;
		reg_addr = a;
		@(posedge clk) #1;
		d = reg_rdata;
	endtask : rd

	task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk($sformatf("reg %h", a), 24'(d), 24'(exp));
	endtask : rchk

	task automatic tally(input logic [2:0] lane);
		wr(A_TEST_CTL, {1'b0, lane, 4'h0});
		rd(A_CNT_L, t[7:0]);
		rd(A_CNT_M, t[15:8]);
		rd(A_CNT_H, t[23:16]);
	endtask : tally

	// timed pattern run, receiver stopped before the transmitter ends
	task automatic prbs_run(input logic [1:0] rx_p, input logic [1:0] tx_p, input logic [7:0] lim);
		pat_sel = tx_p;
		wr(A_LIM_L, lim);
		wr(A_LIM_M, lim);
		wr(A_LIM_H, lim);
		wr(A_TEST_CTL, {4'h0, rx_p, 2'h1});
		wr(A_TEST_CTL, {4'h0, rx_p, 2'h0});
		prbs_start = 1'b1;
		@(posedge clk) #1;
		prbs_start = 1'b0;
		wr(A_TEST_CTL, {4'h0, rx_p, 2'h2});
		repeat (200) @(posedge clk);
		#1;
		wr(A_TEST_CTL, {4'h0, rx_p, 2'h0});
		for (n = 0; n < 400 && prbs_run_done !== 1'b1; n++)
			@(posedge clk) #1;
		chk("run end", 24'(prbs_run_done), 24'h1);
		if (prbs_run_done !== 1'b1)
			wrap_up();
	endtask : prbs_run

	initial begin
		repeat (5) @(posedge clk);
		#1;
		nrst = 1'b1;
		foreach (zero_a[k])
			rchk(zero_a[k], REG_RESET);
		foreach (rw_a[k])
			wr(rw_a[k], 8'h5a ^ 8'(k));
		foreach (rw_a[k])
			rchk(rw_a[k], 8'h5a ^ 8'(k));
		foreach (zero_a[k])
			if (k > 1 && k != 5)
				wr(zero_a[k], 8'hff);
		foreach (zero_a[k])
			if (k > 1 && k != 5)
				rchk(zero_a[k], (k == 2) ? 8'h5a : 8'h00);
		wr(A_L_CFG, 8'h81);
		rchk(A_L_CFG, 8'h81);
		chk("descramble", {descramble_en, 18'h0, lanes_per_link_m1}, 24'h800001);
		wr(A_L_CFG, 8'h01);
		rchk(A_M_CFG, 8'h5a ^ 8'h08);
		chk("descramble off", {descramble_en, 18'h0, lanes_per_link_m1}, 24'h000001);
		chk("mode 11", 24'({tx_lanes, tx_convs, rx_lane_mask}),
			24'({TX_L_MODE11, TX_M_TRUE, MASK_MODE11}));
		mode = MODE_12;
		@(posedge clk) #1;
		chk("mode 12", 24'({tx_lanes, tx_convs, rx_lane_mask}),
			24'({TX_L_MODE12, TX_M_TRUE, MASK_MODE12}));
		mode = MODE_11;
		wr(A_LANE_EN, 8'h1f);
		for (i = 0; i < 3; i++) begin
			prbs_run(pats[i], pats[i], 8'h00);
			rchk(A_PASS, 8'h1f);
			tally(3'h1);
			chk("tally clean", t, 24'h0);
		end
		prbs_run(PAT_PRBS7, PAT_PRBS15, 8'h00);
		rchk(A_PASS, 8'h10);
		tally(3'h0);
		chk("tally errors", 24'(t != 24'h0), 24'h1);
		tally(3'h4);
		chk("tally quiet lane", t, 24'h0);
		prbs_run(PAT_PRBS7, PAT_PRBS15, 8'hff);
		rchk(A_PASS, 8'h1f);
		wr(A_LANE_MASK, MASK_MODE11);
		wr(A_DESKEW, MASK_MODE11);
		cgs_send = 1'b1;
		for (n = 0; n < 20 && link.sync_request_out_n !== 1'b1; n++)
			@(posedge clk) #1;
		chk("sync released", 24'(link.sync_request_out_n), 24'h1);
		rchk(A_CGS_STAT, MASK_MODE11);
		rchk(A_LANE_MASK, MASK_MODE11);
		wr(A_LINK_CFG, 8'h04);
		rchk(A_CGS_STAT, 8'h03);
		wr(A_LINK_CFG, 8'h00);
		short_transport_check_en = 1'b1;
		for (i = 0; i < 4; i++) begin
			t[15:0] = (short_transport_check_base + {12'h0, cvs[i], 2'h0}) ^ flip[i];
			wr(A_REF_L, t[7:0]);
			wr(A_REF_H, t[15:8]);
			wr(A_SHORT_TRANSPORT_CHECK_CTL, {2'h0, idxs[i], cvs[i], 2'h1});
			wr(A_SHORT_TRANSPORT_CHECK_CTL, {2'h0, idxs[i], cvs[i], 2'h3});
			wr(A_SHORT_TRANSPORT_CHECK_CTL, {2'h0, idxs[i], cvs[i], 2'h1});
			repeat (4) @(posedge clk);
			#1;
			rchk(A_SHORT_TRANSPORT_CHECK_RES, {7'h0, i == 2});
		end
		wrap_up();
	end
endmodule : tb_serial_link_rx_test_checker
`default_nettype wire
